/* hdl/local_bus_if.sv */
// local_bus_if: processor side of the local bus, with its request queue
// assumes pins arrive unsynchronised and tristate wiring sits outside
`timescale 1ns/10ps
`default_nettype none

// request queue with registered full and empty flags
module req_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic full_q, full_d, empty_q, empty_d, push, pop;

   assign push = in_valid && !full_q;
   assign pop = out_ready && !empty_q;
   assign in_ready = !full_q;
   assign out_valid = !empty_q;
   assign out_data = mem[rp_q];

   // pointer and occupancy update
   always_comb
   begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
      full_d = cnt_d == (AW+1)'(DEPTH);
      empty_d = cnt_d == '0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         full_q <= 1'b0;
         empty_q <= 1'b1;
      end
      else
      begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         full_q <= full_d;
         empty_q <= empty_d;
      end
   end

   // storage write
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wp_q] <= in_data;
   end
endmodule

module local_bus_if (
   input wire logic sys_clk,
   input wire logic reset,
   input wire bus_pkg::req_t req_data,
   input wire logic req_valid,
   output logic req_ready,
   output logic rd_valid,
   output logic [31:0] rd_data,
   output logic [1:0] rd_beat,
   output logic parity_err,
   output logic snoop_valid,
   output logic [31:4] snoop_addr,
   output logic cache_flush,
   output logic test_float,
   input wire logic address_wrap_mask_n,
   input wire logic addr_float_req,
   input wire logic bus_yield_n,
   input wire logic burst_done_n,
   input wire logic cycle_done_n,
   input wire logic narrow8_size_n,
   input wire logic narrow16_size_n,
   input wire logic snoop_addr_strobe_n,
   input wire logic cache_invalidate_all_n,
   input wire logic bus_surrender_req,
   input wire logic [31:4] addr_pin_in,
   output logic [31:2] addr_pin_out,
   output logic addr_pin_oe,
   output logic addr_strobe_n,
   output logic [3:0] byte_lane_sel_n,
   output logic final_transfer_n,
   output logic ctl_oe,
   input wire logic [31:0] data_pin_in,
   input wire logic [3:0] lane_parity_in,
   output logic [31:0] data_pin_out,
   output logic [3:0] lane_parity_out,
   output logic data_pin_oe,
   output logic internal_request_pending,
   output logic request_pending_oe,
   output logic bus_surrender_ack,
   output logic surrender_ack_oe
);
   import bus_pkg::*;

   pins_in_t raw, s1_q, in;
   pins_out_t p_d, p_q;
   req_t cur_q, cur_d, fifo_out;
   bus_state_t state_q, state_d;
   logic [3:0] rem_q, rem_d, srv;
   logic [1:0] beat_q, beat_d, age_q, age_d, rd_beat_q, rd_beat_d;
   logic [31:0] rd_data_q, rd_data_d;
   logic busy_q, busy_d, rd_valid_q, rd_valid_d, perr_q, perr_d, take, rdy, flt, on;
   logic fifo_valid, first_q, test_q, test_d, flush_q, flush_d;
   logic snoop_q, snoop_d, ads_prev_q, hold_prev_q, win;
   logic [27:0] saddr_q, saddr_d;
   logic [29:0] a;

   // even parity per byte: parity bit makes each byte plus bit even
   function automatic logic [3:0] even_par(input logic [31:0] d);
      logic [3:0] r;
      r = '0;
      for (int i = 0; i < 4; i++)
         r[i] = ^d[8*i +: 8];
      return r;
   endfunction

   // lanes served by one cycle at the sampled port width
   function automatic logic [3:0] served(input logic [3:0] rem, input logic n8_n, input logic n16_n);
      logic [3:0] r;
      r = rem;
      if (!n8_n)
         r = rem & (4'(~rem) + 4'h1);
      else if (!n16_n)
         r = (|rem[1:0]) ? {2'b00, rem[1:0]} : {rem[3:2], 2'b00};
      return r;
   endfunction

   req_fifo #(.WIDTH($bits(req_t)), .DEPTH(FIFO_DEPTH)) u_queue (
      .clk(sys_clk),
      .rst(reset),
      .in_valid(req_valid),
      .in_data(req_data),
      .in_ready(req_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_out),
      .out_ready(take)
   );

   // two-stage pin synchroniser, no reset so reset-time levels pass through
   assign raw = {address_wrap_mask_n, addr_float_req, bus_yield_n, burst_done_n, cycle_done_n,
                 narrow8_size_n, narrow16_size_n, snoop_addr_strobe_n, cache_invalidate_all_n,
                 bus_surrender_req, addr_pin_in, data_pin_in, lane_parity_in};
   always_ff @(posedge sys_clk)
   begin
      s1_q <= raw;
      in <= s1_q;
   end

   // cycle sequencer
   always_comb
   begin
      state_d = state_q;
      cur_d = cur_q;
      rem_d = rem_q;
      beat_d = beat_q;
      busy_d = busy_q;
      rd_data_d = rd_data_q;
      rd_beat_d = rd_beat_q;
      rd_valid_d = 1'b0;
      perr_d = perr_q;
      take = 1'b0;
      srv = served(rem_q, in.n8_n, in.n16_n);
      rdy = !in.cycle_done_n || (!in.burst_done_n && !cur_q.burst);
      case (state_q)
         ST_IDLE:
            if (!in.yield_n)
               state_d = ST_BACKOFF;
            else if (in.surrender_req)
               state_d = ST_HOLD;
            else if (fifo_valid && !in.float_req && !test_q)
            begin
               take = 1'b1;
               cur_d = fifo_out;
               rem_d = fifo_out.lanes;
               beat_d = '0;
               busy_d = 1'b1;
               state_d = ST_ADDR;
            end
         ST_ADDR:
            state_d = in.yield_n ? ST_DATA : ST_BACKOFF;
         ST_DATA:
            if (!in.yield_n)
               state_d = ST_BACKOFF;
            else if (rdy)
            begin
               for (int i = 0; i < 4; i++)
                  if (srv[i])
                     rd_data_d[8*i +: 8] = in.data[8*i +: 8];
               perr_d = |((even_par(in.data) ^ in.par) & srv);
               rd_beat_d = '0;
               rem_d = rem_q & ~srv;
               if (rem_d != '0)
                  state_d = ST_ADDR;
               else
               begin
                  rd_valid_d = !cur_q.write;
                  busy_d = 1'b0;
                  state_d = ST_IDLE;
               end
            end
            else if (!in.burst_done_n)
            begin
               rd_data_d = in.data;
               perr_d = |(even_par(in.data) ^ in.par);
               rd_beat_d = beat_q;
               rd_valid_d = !cur_q.write;
               beat_d = beat_q + 2'h1;
               if (beat_q == LAST_BEAT)
               begin
                  busy_d = 1'b0;
                  state_d = ST_IDLE;
               end
            end
         ST_BACKOFF:
            if (in.yield_n && !(busy_q && in.float_req))
            begin
               rem_d = cur_q.lanes;
               beat_d = '0;
               state_d = busy_q ? ST_ADDR : ST_IDLE;
            end
         ST_HOLD:
            if (!in.yield_n)
               state_d = ST_BACKOFF;
            else if (!in.surrender_req)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   // pin values for the next clock
   always_comb
   begin
      flt = test_d || state_d == ST_BACKOFF || state_d == ST_HOLD;
      on = state_d == ST_ADDR || state_d == ST_DATA;
      a = cur_d.addr;
      if (!in.wrap_mask_n)
         a[A20_BIT-WORD_LSB] = 1'b0;
      p_d.addr = a;
      p_d.addr_oe = !flt && !in.float_req;
      p_d.ads_n = !(state_d == ST_ADDR);
      p_d.lanes_n = on ? ~rem_d : LANES_IDLE;
      p_d.final_n = !(on && (!cur_d.burst || beat_d == LAST_BEAT));
      p_d.ctl_oe = !flt;
      p_d.data = cur_d.wdata;
      p_d.parity = even_par(cur_d.wdata);
      p_d.data_oe = !flt && state_d == ST_DATA && cur_d.write;
      p_d.req_pend = fifo_valid || busy_d;
      p_d.req_pend_oe = !test_d;
      p_d.ack = state_d == ST_HOLD;
      p_d.ack_oe = !test_d;
   end

   // snoop window, flush and test-float capture
   always_comb
   begin
      age_d = (in.float_req || !in.yield_n) ? ((age_q == SNOOP_AGE) ? age_q : age_q + 2'h1) : 2'h0;
      win = (state_q == ST_HOLD && hold_prev_q) || age_q == SNOOP_AGE;
      snoop_d = !in.snoop_n && win && !ads_prev_q && !snoop_q;
      saddr_d = in.addr_hi;
      if (!in.wrap_mask_n)
         saddr_d[A20_BIT-SNOOP_LSB] = 1'b0;
      flush_d = !in.flush_n && !first_q;
      test_d = first_q ? !in.flush_n : test_q;
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state_q <= ST_IDLE;
         cur_q <= '0;
         rem_q <= '0;
         beat_q <= '0;
         busy_q <= 1'b0;
         rd_data_q <= '0;
         rd_beat_q <= '0;
         rd_valid_q <= 1'b0;
         perr_q <= 1'b0;
         p_q <= '{ads_n: 1'b1, lanes_n: LANES_IDLE, final_n: 1'b1, default: '0};
         age_q <= '0;
         snoop_q <= 1'b0;
         saddr_q <= '0;
         ads_prev_q <= 1'b0;
         hold_prev_q <= 1'b0;
         flush_q <= 1'b0;
         first_q <= 1'b1;
         test_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cur_q <= cur_d;
         rem_q <= rem_d;
         beat_q <= beat_d;
         busy_q <= busy_d;
         rd_data_q <= rd_data_d;
         rd_beat_q <= rd_beat_d;
         rd_valid_q <= rd_valid_d;
         perr_q <= perr_d;
         p_q <= p_d;
         age_q <= age_d;
         snoop_q <= snoop_d;
         saddr_q <= saddr_d;
         ads_prev_q <= !p_q.ads_n;
         hold_prev_q <= p_q.ack;
         flush_q <= flush_d;
         first_q <= 1'b0;
         test_q <= test_d;
      end
   end

   // outputs straight from flops
   assign rd_valid = rd_valid_q;
   assign rd_data = rd_data_q;
   assign rd_beat = rd_beat_q;
   assign parity_err = perr_q;
   assign snoop_valid = snoop_q;
   assign snoop_addr = saddr_q;
   assign cache_flush = flush_q;
   assign test_float = test_q;
   assign addr_pin_out = p_q.addr;
   assign addr_pin_oe = p_q.addr_oe;
   assign addr_strobe_n = p_q.ads_n;
   assign byte_lane_sel_n = p_q.lanes_n;
   assign final_transfer_n = p_q.final_n;
   assign ctl_oe = p_q.ctl_oe;
   assign data_pin_out = p_q.data;
   assign lane_parity_out = p_q.parity;
   assign data_pin_oe = p_q.data_oe;
   assign internal_request_pending = p_q.req_pend;
   assign request_pending_oe = p_q.req_pend_oe;
   assign bus_surrender_ack = p_q.ack;
   assign surrender_ack_oe = p_q.ack_oe;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_write_addr;
      !p_q.ads_n && p_q.ctl_oe && cur_q.write;
   endsequence

   a_wrap_mask: assert property ($past(!in.wrap_mask_n) && p_q.addr_oe |-> !p_q.addr[A20_BIT-WORD_LSB])
      else $error("address bit 20 not masked");
   a_addr_float: assert property ($past(in.float_req) |-> !p_q.addr_oe)
      else $error("address still driven in address hold");
   a_hold_float: assert property (p_q.ack |-> !p_q.ctl_oe && !p_q.addr_oe && !p_q.data_oe)
      else $error("bus driven during hold");
   a_backoff_float: assert property ($past(!in.yield_n) |-> !p_q.ctl_oe && !p_q.addr_oe && !p_q.ack)
      else $error("back-off did not float the bus");
   a_backoff_wins: assert property (state_q == ST_DATA && !in.yield_n |=> state_q == ST_BACKOFF && !rd_valid_q)
      else $error("ready completed a yielded cycle");
   a_restart_cycle: assert property (state_q == ST_BACKOFF && in.yield_n && busy_q && !in.float_req
                                     |=> !p_q.ads_n ##1 p_q.final_n == $past(p_q.final_n))
      else $error("yielded cycle not restarted");
   a_first_clock: assert property (state_q == ST_ADDR && in.yield_n |=> state_q == ST_DATA && !rd_valid_q)
      else $error("ready taken in first clock");
   a_both_ready: assert property (state_q == ST_DATA && in.yield_n && !in.cycle_done_n && !in.burst_done_n
                                  && cur_q.burst |=> beat_q == $past(beat_q))
      else $error("burst ready counted with non-burst ready");
   a_req_pending: assert property (busy_q && !test_q |-> internal_request_pending && request_pending_oe)
      else $error("pending request not shown");
   a_narrow8_split: assert property (state_q == ST_DATA && in.yield_n && !in.cycle_done_n && !in.n8_n
                                     && $countones(rem_q) > 1 |=> state_q == ST_ADDR)
      else $error("8-bit port not split");
   a_write_data: assert property (s_write_addr ##1 state_q == ST_DATA |-> p_q.data_oe
                                  && p_q.parity == even_par(p_q.data))
      else $error("write data or parity missing");
   a_snoop_gap: assert property (snoop_valid |=> !snoop_valid)
      else $error("snoop accepted back to back");
   a_flush_pulse: assert property ($past(!in.flush_n) && !$past(first_q) |-> cache_flush)
      else $error("flush not passed on");
   a_test_float: assert property (test_q |-> !request_pending_oe && !surrender_ack_oe && !ctl_oe)
      else $error("pins driven in test float");
   a_surrender_ack: assert property (state_q == ST_IDLE && in.yield_n && in.surrender_req |=> bus_surrender_ack
                                     && !ctl_oe)
      else $error("surrender not acknowledged");
endmodule

`default_nettype wire

/* hdl/bus_pkg.sv */
// bus_pkg: constants, states and carriers of the local bus interface
// assumes one 25 MHz clock; pin directions are resolved outside by the enables
// Functional notes
// - mask wrap low forces address bit 20 zero
// - address pins float in bus or address hold
// - address strobe with address; floats in hold
// - address float request floats address next clock
// - lane selects mark active bytes; float in hold
// - final transfer low before completing ready
// - yield floats bus, no ack, until released
// - yield beats a ready in same clock
// - yielded cycle restarts from its beginning
// - burst ready ignored idle and first clock
// - both readies low means non-burst completion
// - request pending shows queued or running work
// - narrow sizes split into four or two
// - write data and parity from second clock
// - even parity written; read parity never acts
// - snoop strobe honoured only while off bus
// - snoop first sampled late; trigger held after
// - one-clock flush pulse invalidates whole cache
// - flush low at reset release floats pins
// - surrender after cycle ends; ack until withdrawn
package bus_pkg;
   localparam int A20_BIT = 20;
   localparam int WORD_LSB = 2;
   localparam int SNOOP_LSB = 4;
   localparam int FIFO_DEPTH = 16;
   localparam logic [1:0] LAST_BEAT = 2'h3;
   localparam logic [1:0] SNOOP_AGE = 2'h2;
   localparam logic [3:0] LANES_IDLE = 4'hf;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_DATA = 3'b010,
      ST_BACKOFF = 3'b011,
      ST_HOLD = 3'b100
   } bus_state_t;

   // one core request: word address, lanes, direction, line fill, data
   typedef struct packed {
      logic [29:0] addr;
      logic [3:0] lanes;
      logic write;
      logic burst;
      logic [31:0] wdata;
   } req_t;

   typedef struct packed {
      logic wrap_mask_n;
      logic float_req;
      logic yield_n;
      logic burst_done_n;
      logic cycle_done_n;
      logic n8_n;
      logic n16_n;
      logic snoop_n;
      logic flush_n;
      logic surrender_req;
      logic [27:0] addr_hi;
      logic [31:0] data;
      logic [3:0] par;
   } pins_in_t;

   typedef struct packed {
      logic [29:0] addr;
      logic addr_oe;
      logic ads_n;
      logic [3:0] lanes_n;
      logic final_n;
      logic ctl_oe;
      logic [31:0] data;
      logic [3:0] parity;
      logic data_oe;
      logic req_pend;
      logic req_pend_oe;
      logic ack;
      logic ack_oe;
   } pins_out_t;
endpackage

/* bench/chipset_model.sv */
// chipset_model: far-side memory controller answering the local bus
// assumes the device's pins are registered and sampled on the rising edge
`timescale 1ns/10ps
`default_nettype none
module chipset_model (
   input wire logic sys_clk,
   input wire logic addr_strobe_n,
   input wire logic ctl_oe,
   input wire logic [31:2] addr_pin_out,
   input wire logic final_transfer_n,
   input wire logic [31:0] data_pin_out,
   input wire logic [3:0] lane_parity_out,
   input wire logic data_pin_oe,
   input wire logic [3:0] byte_lane_sel_n,
   input wire logic [3:0] lat,
   input wire logic burst_mode,
   input wire logic [1:0] size_sel,
   output logic cycle_done_n,
   output logic burst_done_n,
   output logic narrow8_size_n,
   output logic narrow16_size_n,
   output logic [31:0] data_pin_in,
   output logic [3:0] lane_parity_in
);
   int strobes = 0;
   int readies = 0;
   int wait_q = 0;
   int beats = 0;
   logic [29:0] last_addr;
   logic [3:0] last_lanes;
   logic [3:0] last_par;
   logic [31:0] last_data;
   logic [31:0] rdata;
   logic last_final;

   // even parity per byte
   function automatic logic [3:0] epar(input logic [31:0] d);
      return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
   endfunction

   // size pins low while a cycle is open, through its ready clock; pulled up otherwise
   assign narrow8_size_n = !(size_sel == 2'h1 && (beats != 0 || !cycle_done_n));
   assign narrow16_size_n = !(size_sel == 2'h2 && (beats != 0 || !cycle_done_n));

   // idle levels at start
   initial
   begin
      cycle_done_n = 1'b1;
      burst_done_n = 1'b1;
      data_pin_in = 32'h0;
      lane_parity_in = 4'h0;
   end

   // answer each strobe after lat clocks; released lines toggle every cycle
   always @(posedge sys_clk)
   begin
      rdata = 32'h5a00_0000 + (burst_mode ? 32'(4 - beats) : 32'h0);
      cycle_done_n <= 1'b1;
      burst_done_n <= 1'b1;
      data_pin_in <= ~data_pin_in;
      lane_parity_in <= ~lane_parity_in;
      if (ctl_oe && !addr_strobe_n)
      begin
         strobes <= strobes + 1;
         last_addr <= addr_pin_out;
         last_lanes <= byte_lane_sel_n;
         last_final <= final_transfer_n;
         wait_q <= int'(lat);
         beats <= burst_mode ? 4 : 1;
      end
      else if (!ctl_oe)
         beats <= 0;
      else if (wait_q != 0)
         wait_q <= wait_q - 1;
      else if (beats != 0)
      begin
         readies <= readies + 1;
         last_data <= data_pin_oe ? data_pin_out : ~data_pin_out;
         last_par <= lane_parity_out;
         data_pin_in <= rdata;
         lane_parity_in <= epar(rdata);
         if (burst_mode)
            burst_done_n <= 1'b0;
         else
            cycle_done_n <= 1'b0;
         beats <= beats - 1;
      end
   end
endmodule
`default_nettype wire

/* bench/tb.sv */
// tb: self-checking bench of the local bus interface
// assumes bus_pkg, local_bus_if and chipset_model are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
`define AWAIT(c, lim) begin w = 0; do begin @(posedge sys_clk); #1; w++; end while (!(c) && w < lim); end
module tb;
   import bus_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   req_t req_data = '0;
   logic req_valid = 1'b0;
   logic address_wrap_mask_n = 1'b1;
   logic bus_yield_n = 1'b1;
   logic cache_invalidate_all_n = 1'b1;
   logic bus_surrender_req = 1'b0;
   logic burst_mode = 1'b0;
   logic [1:0] size_sel = 2'h0;
   logic [3:0] lat = 4'h1;
   logic addr_float_req = 1'b0;
   logic snoop_addr_strobe_n = 1'b1;
   logic [31:4] addr_pin_in = 28'h0;
   logic snoop_valid, test_float, request_pending_oe, surrender_ack_oe;
   logic [31:4] snoop_addr;
   logic req_ready, rd_valid, parity_err, cache_flush, addr_pin_oe, addr_strobe_n, final_transfer_n, ctl_oe;
   logic data_pin_oe, internal_request_pending, bus_surrender_ack, cycle_done_n, burst_done_n;
   logic narrow8_size_n, narrow16_size_n;
   logic [31:0] rd_data, data_pin_in, data_pin_out;
   logic [1:0] rd_beat;
   logic [31:2] addr_pin_out;
   logic [3:0] byte_lane_sel_n, lane_parity_in, lane_parity_out;
   int num_errors = 0;
   int checks_done = 0;

   local_bus_if dut (.sys_clk, .reset, .req_data, .req_valid, .req_ready, .rd_valid, .rd_data, .rd_beat,
      .parity_err, .snoop_valid, .snoop_addr, .cache_flush, .test_float, .address_wrap_mask_n,
      .addr_float_req, .bus_yield_n, .burst_done_n, .cycle_done_n, .narrow8_size_n, .narrow16_size_n,
      .snoop_addr_strobe_n, .cache_invalidate_all_n, .bus_surrender_req, .addr_pin_in,
      .addr_pin_out, .addr_pin_oe, .addr_strobe_n, .byte_lane_sel_n, .final_transfer_n, .ctl_oe, .data_pin_in,
      .lane_parity_in, .data_pin_out, .lane_parity_out, .data_pin_oe, .internal_request_pending,
      .request_pending_oe, .bus_surrender_ack, .surrender_ack_oe);

   chipset_model m (.sys_clk, .addr_strobe_n, .ctl_oe, .addr_pin_out, .final_transfer_n, .data_pin_out,
      .lane_parity_out, .data_pin_oe, .byte_lane_sel_n, .lat, .burst_mode, .size_sel, .cycle_done_n,
      .burst_done_n, .narrow8_size_n, .narrow16_size_n, .data_pin_in, .lane_parity_in);

   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;

   function automatic req_t rq(input logic [29:0] a, input logic wr, input logic b, input logic [31:0] d);
      return '{addr: a, lanes: 4'hf, write: wr, burst: b, wdata: d};
   endfunction

   // offer one request until max are taken or maxw refusals pass
   task automatic push(input req_t r, input int max, input int maxw, output int n);
      int w;
      n = 0;
      w = 0;
      req_data = r;
      req_valid = 1'b1;
      while (n < max && w < maxw)
      begin
         if (req_ready === 1'b1)
            n++;
         else
            w++;
         @(posedge sys_clk);
         #1;
      end
      req_valid = 1'b0;
   endtask

   // masked write: address, lanes, data and parity seen on the pins
   task automatic t_write();
      int n, w, r;
      req_t q;
      r = m.readies;
      address_wrap_mask_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      q = rq(30'h0004_1234, 1'b1, 1'b0, 32'h8137_f00e);
      q.lanes = 4'h5;
      push(q, 1, 20, n);
      `AWAIT(m.readies > r, 60)
      `CHK(m.last_addr, 30'h0000_1234)
      `CHK(m.last_lanes, 4'ha)
      `CHK(m.last_final, 1'b0)
      `CHK(m.last_data, 32'h8137_f00e)
      `CHK(m.last_par, {^8'h81, ^8'h37, ^8'hf0, ^8'h0e})
      address_wrap_mask_n = 1'b1;
   endtask

   // single or burst read with beat order and data
   task automatic t_read(input logic bm);
      int n, w;
      burst_mode = bm;
      push(rq(30'h10, 1'b0, bm, 32'h0), 1, 20, n);
      for (int i = 0; i < (bm ? 4 : 1); i++)
      begin
         `AWAIT(rd_valid === 1'b1, 60)
         `CHK(rd_beat, 2'(i))
         `CHK(rd_data, 32'h5a00_0000 + 32'(i))
      end
      `CHK(m.last_final, bm)
      `CHK(parity_err, 1'b0)
      burst_mode = 1'b0;
   endtask

   // 8-bit then 16-bit port splits
   task automatic t_narrow();
      int n, w, k, r, e;
      for (int s = 1; s <= 2; s++)
      begin
         size_sel = 2'(s);
         e = (s == 1) ? 4 : 2;
         k = m.strobes;
         r = m.readies;
         push(rq(30'h20, 1'b1, 1'b0, 32'h1234_5678), 1, 20, n);
         `AWAIT(m.readies >= r + e, 200)
         repeat (20) @(posedge sys_clk);
         #1;
         `CHK(m.strobes - k, e)
      end
      size_sel = 2'h0;
   endtask

   // back-off in the clock of the ready, then restart
   task automatic t_yield();
      int n, w, k;
      k = m.strobes;
      lat = 4'h4;
      push(rq(30'h30, 1'b0, 1'b0, 32'h0), 1, 20, n);
      `AWAIT(cycle_done_n === 1'b0, 60)
      bus_yield_n = 1'b0;
      repeat (6)
      begin
         @(posedge sys_clk);
         #1;
         `CHK(rd_valid, 1'b0)
      end
      `CHK(ctl_oe, 1'b0)
      `CHK(addr_pin_oe, 1'b0)
      `CHK(bus_surrender_ack, 1'b0)
      bus_yield_n = 1'b1;
      `AWAIT(rd_valid === 1'b1, 80)
      `CHK(m.strobes - k, 2)
      `CHK(rd_data, 32'h5a00_0000)
      lat = 4'h1;
   endtask

   // bus surrender with a request waiting
   task automatic t_hold();
      int n, w, k;
      bus_surrender_req = 1'b1;
      `AWAIT(bus_surrender_ack === 1'b1, 20)
      `CHK(ctl_oe, 1'b0)
      `CHK(addr_pin_oe, 1'b0)
      k = m.strobes;
      push(rq(30'h40, 1'b0, 1'b0, 32'h0), 1, 20, n);
      repeat (8) @(posedge sys_clk);
      #1;
      `CHK(internal_request_pending, 1'b1)
      `CHK(bus_surrender_ack, 1'b1)
      `CHK(m.strobes, k)
      bus_surrender_req = 1'b0;
      `AWAIT(rd_valid === 1'b1, 60)
      `CHK(bus_surrender_ack, 1'b0)
   endtask

   // one-clock flush pulse
   task automatic t_flush();
      int c;
      c = 0;
      cache_invalidate_all_n = 1'b0;
      @(posedge sys_clk);
      #1;
      cache_invalidate_all_n = 1'b1;
      repeat (8)
      begin
         @(posedge sys_clk);
         #1;
         if (cache_flush === 1'b1)
            c++;
      end
      `CHK(c, 1)
   endtask

   // fill the queue against a slow far side, then drain it
   task automatic t_fill();
      int n, w, r;
      r = m.readies;
      lat = 4'hf;
      push(rq(30'h50, 1'b1, 1'b0, 32'h0f0f_a5a5), 40, 1, n);
      `CHK(req_ready, 1'b0)
      `CHK(n >= FIFO_DEPTH, 1'b1)
      `CHK(internal_request_pending, 1'b1)
      `AWAIT(m.readies >= r + n, 2000)
      `CHK(m.readies - r, n)
      `AWAIT(internal_request_pending === 1'b0, 20)
      `CHK(internal_request_pending, 1'b0)
      `CHK(req_ready, 1'b1)
      lat = 4'h1;
   endtask

   // snoop under address hold with wrap mask low, then one outside any hold
   task automatic t_snoop();
      int w, c;
      address_wrap_mask_n = 1'b0;
      addr_float_req = 1'b1;
      addr_pin_in = 28'h0130_000;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK(addr_pin_oe, 1'b0)
      snoop_addr_strobe_n = 1'b0;
      @(posedge sys_clk);
      #1;
      snoop_addr_strobe_n = 1'b1;
      `AWAIT(snoop_valid === 1'b1, 6)
      `CHK(snoop_valid, 1'b1)
      `CHK(snoop_addr, 28'h0120_000)
      @(posedge sys_clk);
      #1;
      addr_float_req = 1'b0;
      address_wrap_mask_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      snoop_addr_strobe_n = 1'b0;
      @(posedge sys_clk);
      #1;
      snoop_addr_strobe_n = 1'b1;
      c = 0;
      repeat (6)
      begin
         @(posedge sys_clk);
         #1;
         if (snoop_valid !== 1'b0)
            c++;
      end
      `CHK(c, 0)
   endtask

   // flush low across reset release floats pins; a plain reset leaves test mode
   task automatic t_test();
      int n, k;
      k = m.strobes;
      cache_invalidate_all_n = 1'b0;
      reset = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      @(posedge sys_clk);
      #1;
      cache_invalidate_all_n = 1'b1;
      `CHK(test_float, 1'b1)
      `CHK(ctl_oe, 1'b0)
      `CHK(request_pending_oe, 1'b0)
      `CHK(surrender_ack_oe, 1'b0)
      push(rq(30'h60, 1'b0, 1'b0, 32'h0), 1, 20, n);
      repeat (10) @(posedge sys_clk);
      #1;
      `CHK(m.strobes, k)
      reset = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      @(posedge sys_clk);
      #1;
      `CHK(test_float, 1'b0)
      `CHK(request_pending_oe, 1'b1)
      `CHK(surrender_ack_oe, 1'b1)
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (3) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      @(posedge sys_clk);
      #1;
      t_write();
      t_read(1'b0);
      t_read(1'b1);
      t_narrow();
      t_yield();
      t_hold();
      t_flush();
      t_fill();
      t_snoop();
      t_test();
      stop_test();
   end

   // watchdog
   initial
   begin
      #800000;
      num_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
